/* File: hw/acsr_serial_rx.sv */
// Purpose: serial command receiver, msb first, data taken on sclk rising edge
// Assumes: sclk idles low; sclk, cs_n and din are asynchronous pins
// Notes: sclk must stay below a quarter of the system clock for reliable edges
`timescale 1ns/1ps
module acsr_serial_rx
    import acsr_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    acsr_link_if.rx lnk
);
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic cs_s1;
        logic cs_s2;
        logic din_s1;
        logic din_s2;
        logic [6:0] shift;
        logic [2:0] cnt;
        logic byte_valid;
        logic [7:0] data;
        logic sclk_rise;
    } acsr_rx_s;

    acsr_rx_s st_reg;
    acsr_rx_s st_next;

    // din passes the same two stages as sclk so the sample lines up with the edge
    always_comb begin
        st_next = st_reg;
        st_next.sclk_s1 = sclk;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_s3 = st_reg.sclk_s2;
        st_next.cs_s1 = cs_n;
        st_next.cs_s2 = st_reg.cs_s1;
        st_next.din_s1 = din;
        st_next.din_s2 = st_reg.din_s1;
        st_next.byte_valid = 1'b0;
        st_next.sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_s3;
        if (st_reg.cs_s2) begin
            st_next.cnt = 3'h0; // deselect drops a partial byte
        end else if (st_reg.sclk_s2 && !st_reg.sclk_s3) begin
            st_next.shift = {st_reg.shift[5:0], st_reg.din_s2};
            st_next.cnt = st_reg.cnt + 3'h1;
            if (st_reg.cnt == 3'h7) begin
                st_next.byte_valid = 1'b1;
                st_next.data = {st_reg.shift, st_reg.din_s2};
            end
        end
    end

    // cs_n flops reset high so an idle link looks deselected
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.byte_valid = st_reg.byte_valid;
    assign lnk.byte_data = st_reg.data;
    assign lnk.sclk_rise = st_reg.sclk_rise;
endmodule

/* File: hw/acsr_top.sv */
// Purpose: setup byte decode, clock and pin role select, reference wake-up sequencing
// Assumes: scan_complete, force_reference_on and dac_ref_demand come from logic on clock
// Notes: a scan keeps the settings captured at its start
// Notes on behaviour
// - a byte with bit 7 clear and bit 6 set is a write to the setup register.
// - the upper clock-mode bit is one after reset.
// - clock modes 00 and 01 make the shared pin the start input, 10 and 11 make it analog input seven.
// - modes 00, 01 and 10 use the internal conversion clock, with acquisition timed by the start pin only in 01.
// - mode 11 takes the conversion clock from the host serial clock, which the host keeps at or below 3.6MHz.
// - the reference field picks internal, external single-ended, internal ADC with external DAC, or external differential.
// - in reference modes 00 and 10 an input scan turns the reference off at its end and waits 218 ticks when it was off.
// - a temperature request turns the reference on and waits 244 ticks for it to settle.
// - in reference modes 01 and 11 an input-only scan neither powers the reference nor waits.
// - reference mode 10 is the default after reset.
// - the two low setup bits select which pair configuration register later bytes address.
// - reference modes 00 and 10 make the reference pin analog input six, 01 and 11 make it the external reference.
// - forced reference or DAC demand in mode 00 keeps the reference on, and a temperature scan then waits 188 ticks.
`timescale 1ns/1ps
`include "acsr_consts.svh"
module acsr_top
    import acsr_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic conversion_start_n,
    input wire logic force_reference_on,
    input wire logic dac_ref_demand,
    input wire logic scan_complete,
    output logic clock_mode_sel_hi,
    output logic clock_mode_sel_lo,
    output logic reference_sel_hi,
    output logic reference_sel_lo,
    output logic pair_config_sel_hi,
    output logic pair_config_sel_lo,
    output logic start_pin_selected,
    output logic ref_pin_is_input_six,
    output logic external_conv_clock,
    output logic external_acq_timing,
    output logic internal_reference_en,
    output logic reference_wait,
    output logic convert_go,
    output logic scan_temp,
    output logic conv_tick
);
    typedef struct packed {
        acsr_state_e state;
        logic [5:0] setup;
        logic pin_start;
        logic ref_pin_ain;
        logic ext_clk;
        logic ext_acq;
        logic temp_req;
        logic [1:0] scan_ref;
        logic scan_temp;
        logic scan_ext_clk;
        logic [7:0] delay;
        logic [7:0] dcnt;
        logic [7:0] div;
        logic tick;
        logic start_s1;
        logic start_s2;
        logic start_s3;
        logic ref_on;
        logic ref_en;
        logic wait_q;
        logic go;
    } acsr_core_s;

    acsr_link_if lnk ();
    acsr_core_s st_reg;
    acsr_core_s st_next;

    // byte receiver on the serial pins
    acsr_serial_rx u_rx (
        .clock(clock),
        .arst_n(arst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .lnk(lnk.rx)
    );

    logic forced;
    logic setup_wr;
    logic conv_wr;
    logic pin_fall;
    logic tick_now;

    // reference held on regardless of scans
    assign forced = force_reference_on | (dac_ref_demand & (st_reg.setup[3:2] == `ACSR_REF_ALL_INT));
    assign setup_wr = lnk.byte_valid & (lnk.byte_data[7:6] == `ACSR_SETUP_SEL);
    assign conv_wr = lnk.byte_valid & lnk.byte_data[`ACSR_CONV_SEL_BIT];
    assign pin_fall = st_reg.start_s3 & ~st_reg.start_s2;
    // serial clock ticks only while the host drives it, so mode 11 settling waits stall without it
    assign tick_now = st_reg.scan_ext_clk ? lnk.sclk_rise : (st_reg.div == `ACSR_INT_CLK_DIV);

    // next state: setup decode, pin roles and the reference sequencer
    always_comb begin
        st_next = st_reg;
        st_next.start_s1 = conversion_start_n;
        st_next.start_s2 = st_reg.start_s1;
        st_next.start_s3 = st_reg.start_s2;
        st_next.tick = tick_now;
        st_next.div = (st_reg.div == `ACSR_INT_CLK_DIV) ? 8'h00 : st_reg.div + 8'h01;
        if (setup_wr) begin
            st_next.setup = lnk.byte_data[5:0];
        end
        if (conv_wr) begin
            st_next.temp_req = lnk.byte_data[`ACSR_TEMP_BIT];
        end
        st_next.pin_start = ~st_next.setup[`ACSR_CLK_HI_BIT];
        st_next.ref_pin_ain = ~st_next.setup[`ACSR_REF_LO_BIT];
        st_next.ext_clk = (st_next.setup[5:4] == `ACSR_CLK_EXT);
        st_next.ext_acq = (st_next.setup[5:4] == `ACSR_CLK_ACQ_PIN);
        case (st_reg.state)
            ACSR_IDLE: begin
                // start by pin falling edge in modes 00/01, by conversion write in 10/11
                if ((pin_fall && st_reg.pin_start) || (conv_wr && st_reg.setup[`ACSR_CLK_HI_BIT])) begin
                    st_next.scan_ref = st_reg.setup[3:2];
                    st_next.scan_ext_clk = st_reg.ext_clk;
                    st_next.scan_temp = conv_wr ? lnk.byte_data[`ACSR_TEMP_BIT] : st_reg.temp_req;
                    st_next.temp_req = 1'b0;
                    st_next.dcnt = 8'h00;
                    if (st_next.scan_temp) begin
                        st_next.ref_on = 1'b1;
                        st_next.delay = forced ? `ACSR_DLY_TEMP_ON : `ACSR_DLY_TEMP_WAKE;
                    end else if (!st_reg.setup[`ACSR_REF_LO_BIT]) begin
                        st_next.ref_on = 1'b1;
                        st_next.delay = (st_reg.ref_on || forced) ? 8'h00 : `ACSR_DLY_REF_OFF;
                    end else begin
                        st_next.delay = 8'h00;
                    end
                    st_next.state = (st_next.delay == 8'h00) ? ACSR_CONV : ACSR_WAIT;
                end
            end
            ACSR_WAIT: begin
                if (tick_now) begin
                    st_next.dcnt = st_reg.dcnt + 8'h01;
                    if (st_next.dcnt == st_reg.delay) begin
                        st_next.state = ACSR_CONV;
                    end
                end
            end
            ACSR_CONV: begin
                if (scan_complete) begin
                    st_next.state = ACSR_IDLE;
                    st_next.ref_on = 1'b0;
                end
            end
            default: begin
                st_next.state = ACSR_IDLE;
            end
        endcase
        st_next.ref_en = st_next.ref_on | forced;
        st_next.wait_q = (st_next.state == ACSR_WAIT);
        st_next.go = (st_next.state == ACSR_CONV);
    end

    // state register; pin stage flops reset high to match an idle start pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{state: ACSR_IDLE, setup: `ACSR_SETUP_RST, pin_start: 1'b0, ref_pin_ain: 1'b1,
                        start_s1: 1'b1, start_s2: 1'b1, start_s3: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // every output is a field of the state register
    assign clock_mode_sel_hi = st_reg.setup[`ACSR_CLK_HI_BIT];
    assign clock_mode_sel_lo = st_reg.setup[`ACSR_CLK_LO_BIT];
    assign reference_sel_hi = st_reg.setup[`ACSR_REF_HI_BIT];
    assign reference_sel_lo = st_reg.setup[`ACSR_REF_LO_BIT];
    assign pair_config_sel_hi = st_reg.setup[`ACSR_PAIR_HI_BIT];
    assign pair_config_sel_lo = st_reg.setup[`ACSR_PAIR_LO_BIT];
    assign start_pin_selected = st_reg.pin_start;
    assign ref_pin_is_input_six = st_reg.ref_pin_ain;
    assign external_conv_clock = st_reg.ext_clk;
    assign external_acq_timing = st_reg.ext_acq;
    assign internal_reference_en = st_reg.ref_en;
    assign reference_wait = st_reg.wait_q;
    assign convert_go = st_reg.go;
    assign scan_temp = st_reg.scan_temp;
    assign conv_tick = st_reg.tick;

    // helper: set once any setup write has landed
    logic seen_wr_reg;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seen_wr_reg <= 1'b0;
        end else if (setup_wr) begin
            seen_wr_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_setup_decode: assert property (setup_wr |=> {clock_mode_sel_hi, clock_mode_sel_lo, reference_sel_hi,
        reference_sel_lo, pair_config_sel_hi, pair_config_sel_lo} == $past(lnk.byte_data[5:0]))
        else $error("setup write not applied");
    a_setup_hold: assert property (!setup_wr |=> $stable({clock_mode_sel_hi, reference_sel_hi, pair_config_sel_lo}))
        else $error("setup changed without a setup write");
    a_reset_defaults: assert property (!seen_wr_reg |-> clock_mode_sel_hi && reference_sel_hi && !reference_sel_lo)
        else $error("reset defaults wrong");
    a_pin_role: assert property (start_pin_selected == !clock_mode_sel_hi)
        else $error("start pin role wrong");
    a_clock_source: assert property (external_conv_clock == (clock_mode_sel_hi && clock_mode_sel_lo)
        && external_acq_timing == (!clock_mode_sel_hi && clock_mode_sel_lo))
        else $error("clock source decode wrong");
    a_ref_pin: assert property (ref_pin_is_input_six == !reference_sel_lo)
        else $error("reference pin role wrong");
    a_temp_delay: assert property (st_reg.state == ACSR_IDLE && st_next.state != ACSR_IDLE && st_next.scan_temp
        |=> internal_reference_en && st_reg.delay == ($past(forced) ? 8'hbc : 8'hf4))
        else $error("temperature settle delay wrong");
    a_ext_no_wake: assert property (st_reg.state == ACSR_IDLE && st_next.state != ACSR_IDLE && !st_next.scan_temp
        && reference_sel_lo |=> convert_go && st_reg.delay == 8'h00)
        else $error("external reference scan waited");
    a_wake_wait: assert property ($rose(reference_wait) && st_reg.delay == 8'hda && !st_reg.scan_ext_clk
        |-> reference_wait [*8] ##1 !convert_go)
        else $error("reference wake wait ended early");
    a_ref_off: assert property (st_reg.state == ACSR_CONV && scan_complete && !forced
        |=> !internal_reference_en && !convert_go)
        else $error("reference left on after scan");
    a_force_on: assert property (forced |=> internal_reference_en)
        else $error("forced reference not on");

    c_temp_scan: cover property ($rose(convert_go) && scan_temp);
    c_wake_scan: cover property ($fell(reference_wait) && st_reg.delay == 8'hda);
    c_ext_clock: cover property (convert_go && st_reg.scan_ext_clk);
    c_setup_mid: cover property (convert_go && setup_wr);
endmodule

/* File: pkg/acsr_consts.svh */
// Purpose: constants of the setup decode and reference sequencer
// Assumes: included by bare name wherever needed
// Notes: delays are counted in conversion clock ticks
`ifndef ACSR_CONSTS_SVH
`define ACSR_CONSTS_SVH

// command byte layout
`define ACSR_SETUP_SEL 2'h1
`define ACSR_CONV_SEL_BIT 7
`define ACSR_TEMP_BIT 0
`define ACSR_CLK_HI_BIT 5
`define ACSR_CLK_LO_BIT 4
`define ACSR_REF_HI_BIT 3
`define ACSR_REF_LO_BIT 2
`define ACSR_PAIR_HI_BIT 1
`define ACSR_PAIR_LO_BIT 0

// setup field reset: clock mode 10, reference mode 10, pair select 00
`define ACSR_SETUP_RST 6'h28
`define ACSR_CLK_EXT 2'h3
`define ACSR_CLK_ACQ_PIN 2'h1
`define ACSR_REF_ALL_INT 2'h0

// settling delays in conversion clock ticks
`define ACSR_DLY_REF_OFF 8'hda
`define ACSR_DLY_TEMP_WAKE 8'hf4
`define ACSR_DLY_TEMP_ON 8'hbc

// internal conversion clock: one tick every (divider + 1) system clocks
`define ACSR_INT_CLK_DIV 8'h03

`endif

/* File: pkg/acsr_link_if.sv */
// Purpose: received byte and serial clock edges from the link receiver
// Assumes: single clock domain, driven by the receiver only
// Notes: byte_valid and sclk_rise are one-cycle pulses
`timescale 1ns/1ps
interface acsr_link_if;
    logic byte_valid;
    logic [7:0] byte_data;
    logic sclk_rise;
    modport rx (output byte_valid, output byte_data, output sclk_rise);
    modport core (input byte_valid, input byte_data, input sclk_rise);
endinterface

/* File: pkg/acsr_pkg.sv */
// Purpose: shared types of the setup decode and reference sequencer
// Assumes: nothing beyond the constants header
// Notes: state codes are fixed binary values
package acsr_pkg;
    typedef enum logic [1:0] {
        ACSR_IDLE = 2'h0,
        ACSR_WAIT = 2'h1,
        ACSR_CONV = 2'h2
    } acsr_state_e;
endpackage

/* File: testbench/acsr_host_model.sv */
// Purpose: host side of the serial command link
// Assumes: sclk idles low, data launched while sclk is low
// Notes: 400 ns sclk period keeps the external conversion clock well under its ceiling
`timescale 1ns/1ps
module acsr_host_model (
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // link idle: clock still, not selected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // one byte per frame, msb first; sclk stands still between frames
    task automatic send_byte(input logic [7:0] value);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            din = value[i];
            #200;
            sclk = 1'b1;
            #200;
            sclk = 1'b0;
        end
        #200;
        cs_n = 1'b1;
        din = ~din; // released line must not keep showing the last bit
    endtask
endmodule

/* File: testbench/adc_setup_clock_reference_control_tb.sv */
// Purpose: self-checking bench for setup decode and reference sequencing
// Assumes: scan_complete driven by the bench in place of the converter
// Notes: settling waits are counted on conv_tick pulses
`timescale 1ns/1ps
module adc_setup_clock_reference_control_tb;
    logic clock, arst_n, sclk, cs_n, din, conversion_start_n, force_reference_on, dac_ref_demand, scan_complete;
    logic clock_mode_sel_hi, clock_mode_sel_lo, reference_sel_hi, reference_sel_lo;
    logic pair_config_sel_hi, pair_config_sel_lo, start_pin_selected, ref_pin_is_input_six;
    logic external_conv_clock, external_acq_timing, internal_reference_en, reference_wait;
    logic convert_go, scan_temp, conv_tick;
    int num_errors = 0;
    int cmp_count = 0;

    acsr_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din));
    acsr_top u_dut (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .conversion_start_n(conversion_start_n), .force_reference_on(force_reference_on),
        .dac_ref_demand(dac_ref_demand), .scan_complete(scan_complete),
        .clock_mode_sel_hi(clock_mode_sel_hi), .clock_mode_sel_lo(clock_mode_sel_lo),
        .reference_sel_hi(reference_sel_hi), .reference_sel_lo(reference_sel_lo),
        .pair_config_sel_hi(pair_config_sel_hi), .pair_config_sel_lo(pair_config_sel_lo),
        .start_pin_selected(start_pin_selected), .ref_pin_is_input_six(ref_pin_is_input_six),
        .external_conv_clock(external_conv_clock), .external_acq_timing(external_acq_timing),
        .internal_reference_en(internal_reference_en), .reference_wait(reference_wait),
        .convert_go(convert_go), .scan_temp(scan_temp), .conv_tick(conv_tick));

    // 50 ns system clock
    always #25 clock = ~clock;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // inputs change 1 ns after the edge, outputs are read there too
    task automatic step();
        @(posedge clock);
        #1;
    endtask

    task automatic check_fields(input logic [1:0] ck, input logic [1:0] rf, input logic [1:0] pr);
        check_bit("clock_hi", ck[1], clock_mode_sel_hi);
        check_bit("clock_lo", ck[0], clock_mode_sel_lo);
        check_bit("ref_hi", rf[1], reference_sel_hi);
        check_bit("ref_lo", rf[0], reference_sel_lo);
        check_bit("pair_hi", pr[1], pair_config_sel_hi);
        check_bit("pair_lo", pr[0], pair_config_sel_lo);
        check_bit("start_pin", ~ck[1], start_pin_selected);
        check_bit("ext_clock", ck == 2'h3, external_conv_clock);
        check_bit("ext_acq", ck == 2'h1, external_acq_timing);
        check_bit("ref_pin_six", ~rf[0], ref_pin_is_input_six);
    endtask

    task automatic write_setup(input logic [1:0] ck, input logic [1:0] rf, input logic [1:0] pr);
        u_host.send_byte({2'h1, ck, rf, pr});
        repeat (4) step();
        check_fields(ck, rf, pr);
    endtask

    // waits out the settling delay counting ticks, then ends the scan
    // a tick counts only when the wait stood in the cycle before it, as the sequencer counts it
    task automatic run_scan(input int exp_ticks, input logic exp_temp, input logic exp_on, input logic exp_after);
        int n;
        int ticks;
        logic prev_wait;
        n = 0;
        ticks = 0;
        prev_wait = 1'b0;
        while (!(reference_wait === 1'b1 || convert_go === 1'b1) && n < 3000) begin
            step();
            n++;
        end
        while (convert_go !== 1'b1 && n < 3000) begin
            if (prev_wait && conv_tick === 1'b1) ticks++;
            prev_wait = reference_wait;
            step();
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            stop_test();
        end
        if (prev_wait && conv_tick === 1'b1) ticks++;
        check_count("settle_ticks", exp_ticks, ticks);
        check_bit("scan_temp", exp_temp, scan_temp);
        check_bit("reference_on", exp_on, internal_reference_en);
        scan_complete = 1'b1;
        step();
        scan_complete = 1'b0;
        step();
        check_bit("scan_ended", 1'b0, convert_go);
        check_bit("reference_after", exp_after, internal_reference_en);
    endtask

    // the byte goes out while the bench already watches, so no tick of the wait is missed
    task automatic byte_scan(input logic [7:0] cmd, input int exp_ticks, input logic exp_temp, input logic exp_on,
        input logic exp_after);
        fork
            u_host.send_byte(cmd);
            run_scan(exp_ticks, exp_temp, exp_on, exp_after);
        join
    endtask

    task automatic test_setup_modes();
        for (int m = 0; m < 4; m++) begin
            write_setup(m[1:0], m[1:0], 2'(3 - m));
        end
        u_host.send_byte(8'h0c);
        repeat (4) step();
        check_fields(2'h3, 2'h3, 2'h0);
        write_setup(2'h2, 2'h2, 2'h0);
    endtask

    // setup write in mid-wait must not change the running scan
    task automatic test_ain_scan();
        fork
            byte_scan(8'h80, 218, 1'b0, 1'b1, 1'b0);
            begin
                repeat (100) step();
                write_setup(2'h2, 2'h1, 2'h0);
            end
        join
        write_setup(2'h2, 2'h2, 2'h0);
    endtask

    task automatic test_pin_start();
        write_setup(2'h0, 2'h1, 2'h0);
        u_host.send_byte(8'h80);
        repeat (10) step();
        check_bit("byte_no_start", 1'b0, convert_go);
        conversion_start_n = 1'b0;
        repeat (4) step();
        conversion_start_n = 1'b1;
        run_scan(0, 1'b0, 1'b0, 1'b0);
    endtask

    // dac demand in reference mode 00, then the force input in mode 10
    task automatic test_forced_ref();
        write_setup(2'h2, 2'h0, 2'h0);
        dac_ref_demand = 1'b1;
        step();
        byte_scan(8'h81, 188, 1'b1, 1'b1, 1'b1);
        write_setup(2'h2, 2'h2, 2'h0);
        dac_ref_demand = 1'b0;
        force_reference_on = 1'b1;
        step();
        byte_scan(8'h81, 188, 1'b1, 1'b1, 1'b1);
        byte_scan(8'h80, 0, 1'b0, 1'b1, 1'b1);
        force_reference_on = 1'b0;
        step();
        check_bit("reference_released", 1'b0, internal_reference_en);
    endtask

    // reset dropped in the middle of a wake wait, then a delay-free scan in clock mode 11
    task automatic test_mid_reset();
        write_setup(2'h2, 2'h0, 2'h1);
        u_host.send_byte(8'h80);
        repeat (10) step();
        check_bit("wait_before_reset", 1'b1, reference_wait);
        arst_n = 1'b0;
        step();
        check_fields(2'h2, 2'h2, 2'h0);
        check_bit("wait_in_reset", 1'b0, reference_wait);
        check_bit("reference_in_reset", 1'b0, internal_reference_en);
        arst_n = 1'b1;
        step();
        check_fields(2'h2, 2'h2, 2'h0);
        step();
        check_bit("go_after_reset", 1'b0, convert_go);
        write_setup(2'h3, 2'h1, 2'h0);
        byte_scan(8'h80, 0, 1'b0, 1'b0, 1'b0);
        write_setup(2'h2, 2'h2, 2'h0);
    endtask

    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        conversion_start_n = 1'b1;
        force_reference_on = 1'b0;
        dac_ref_demand = 1'b0;
        scan_complete = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        arst_n = 1'b1;
        step();
        check_fields(2'h2, 2'h2, 2'h0);
        test_setup_modes();
        test_ain_scan();
        byte_scan(8'h81, 244, 1'b1, 1'b1, 1'b0);
        test_pin_start();
        test_forced_ref();
        test_mid_reset();
        stop_test();
    end
endmodule
